// >>> design/ldc_top.sv
// top of the ladder reference converter control: registers, routing and pin overrides
// assumes pad inputs are asynchronous; analog switches take the registered selects
`timescale 1ns/1ps
module ladder_dac_control
    import ldc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdata,
    input wire logic [CHAN_W-1:0] adcChannelSelect,
    input wire logic [1:0] padIn,
    input wire logic [1:0] digOut,
    input wire logic [1:0] digOe,
    input wire logic [1:0] pullUpReq,
    input wire logic [1:0] currentDriveReq,
    output logic [1:0] pinReadVal,
    output logic [1:0] pinOut,
    output logic [1:0] pinOe,
    output logic [1:0] pullUpEn,
    output logic [1:0] currentDriveEn,
    output logic [1:0] inputDetEn,
    output logic ladderPowerEn,
    output logic [LEVEL_W-1:0] ladderTap,
    output logic srcSupplyEn,
    output logic srcExtPinEn,
    output logic srcFixedEn,
    output logic cmpPosConnect,
    output logic adcInputConnect,
    output logic refOutPinA,
    output logic refOutPinB
);
    ldc_regs_if ctl ();
    logic [1:0] padSync1_r, padSync2_r;
    logic [1:0] refSel;
    logic [1:0] readC, outC, oeC, puC, cdC, idC;
    logic [DATA_W-1:0] statusVal;
    logic run;
    logic [1:0] rd_r, out_r, oe_r, pu_r, cd_r, id_r;
    logic [1:0] rd_nxt, out_nxt, oe_nxt, pu_nxt, cd_nxt, id_nxt;
    logic pwr_r, pwr_nxt, sup_r, sup_nxt, ext_r, ext_nxt, fix_r, fix_nxt;
    logic cmp_r, cmp_nxt, adc_r, adc_nxt, pa_r, pa_nxt, pb_r, pb_nxt;
    logic [LEVEL_W-1:0] tap_r, tap_nxt;

    function automatic logic src_is(input ldc_src_e s, input ldc_src_e want, input logic en);
        src_is = en && (s == want);
    endfunction

    ldc_regfile u_regs (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWr(regWr),
        .regRd(regRd),
        .statusIn(statusVal),
        .regRdata(regRdata),
        .ctl(ctl.regs)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers on the pad inputs
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            padSync1_r <= 2'h0;
            padSync2_r <= 2'h0;
        end else begin
            padSync1_r <= padIn;
            padSync2_r <= padSync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign run = ctl.enable; // RULE1
    // reserved source code enables none of the three sources rather than shorting two sources
    assign refSel[0] = run && ctl.oe1; // RULE6 RULE15
    assign refSel[1] = run && ctl.oe2; // RULE6 RULE15
    assign statusVal = {4'h0, adc_r, cmp_r, pb_r, pa_r};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            ldc_pin_ctl u_pin (
                .refSel(refSel[g]),
                .padIn(padSync2_r[g]),
                .digOut(digOut[g]),
                .digOe(digOe[g]),
                .pullUpReq(pullUpReq[g]),
                .currentDriveReq(currentDriveReq[g]),
                .readVal(readC[g]),
                .pinOut(outC[g]),
                .pinOe(oeC[g]),
                .pullUpEn(puC[g]),
                .currentDriveEn(cdC[g]),
                .inputDetEn(idC[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        pwr_nxt = run; // RULE1
        // tap index selects code/32 of the span above the negative end
        tap_nxt = run ? ctl.level : LEVEL_RESET; // RULE2 RULE3 RULE14
        sup_nxt = src_is(ctl.srcSel, SRC_SUPPLY, run); // RULE4 RULE11
        ext_nxt = src_is(ctl.srcSel, SRC_EXT_PIN, run); // RULE4 RULE11
        fix_nxt = src_is(ctl.srcSel, SRC_FIXED, run); // RULE4 RULE11
        cmp_nxt = run; // RULE5 RULE15
        adc_nxt = run && (adcChannelSelect == CHAN_DAC); // RULE5 RULE13
        pa_nxt = refSel[0]; // RULE5
        pb_nxt = refSel[1]; // RULE5
        rd_nxt = readC; // RULE8
        out_nxt = outC;
        oe_nxt = oeC;
        pu_nxt = puC;
        cd_nxt = cdC;
        id_nxt = idC;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pwr_r <= 1'b0; // RULE10
            tap_r <= LEVEL_RESET;
            sup_r <= 1'b0;
            ext_r <= 1'b0;
            fix_r <= 1'b0;
            cmp_r <= 1'b0;
            adc_r <= 1'b0;
            pa_r <= 1'b0; // RULE10
            pb_r <= 1'b0;
            rd_r <= 2'h0;
            out_r <= 2'h0;
            oe_r <= 2'h0;
            pu_r <= 2'h0;
            cd_r <= 2'h0;
            id_r <= 2'h3;
        end else begin
            pwr_r <= pwr_nxt;
            tap_r <= tap_nxt;
            sup_r <= sup_nxt;
            ext_r <= ext_nxt;
            fix_r <= fix_nxt;
            cmp_r <= cmp_nxt;
            adc_r <= adc_nxt;
            pa_r <= pa_nxt;
            pb_r <= pb_nxt;
            rd_r <= rd_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pu_r <= pu_nxt;
            cd_r <= cd_nxt;
            id_r <= id_nxt;
        end
    end

    assign ladderPowerEn = pwr_r;
    assign ladderTap = tap_r;
    assign srcSupplyEn = sup_r;
    assign srcExtPinEn = ext_r;
    assign srcFixedEn = fix_r;
    assign cmpPosConnect = cmp_r;
    assign adcInputConnect = adc_r;
    assign refOutPinA = pa_r;
    assign refOutPinB = pb_r;
    assign pinReadVal = rd_r;
    assign pinOut = out_r;
    assign pinOe = oe_r;
    assign pullUpEn = pu_r;
    assign currentDriveEn = cd_r;
    assign inputDetEn = id_r;
endmodule

// >>> design/ldc_pkg.sv
// package for the ladder reference converter control block
// assumes a single 50 MHz system clock and a synchronous active-low device reset
//
// Functional notes
// RULE1 - converter runs only while software holds the enable bit set
// RULE2 - thirty-two output levels chosen by a five-bit level code
// RULE3 - tap voltage is negative source plus span times code over thirty-two
// RULE4 - positive end is supply, external reference pin or fixed reference
// RULE5 - output feeds comparator positive input, adc channel and reference pins
// RULE6 - each pin output enable connects the level to its own pin
// RULE7 - reference pin overrides digital driver, input detector, pull-up, current drive
// RULE8 - digital read of a pin used for reference output returns zero
// RULE9 - keeps running in sleep; wake leaves first control register unchanged
// RULE10 - device reset disables converter, disconnects pins, clears level code
// RULE11 - source select 00 supply, 01 reference pin, 10 fixed reference, 11 reserved
// RULE12 - level code sits in bits 4..0, bits 7..5 read zero
// RULE13 - adc selector picks converter output for channel code 111101
// RULE14 - level and source writes take effect on next clock edge while running; the code latches them on that edge and the outputs follow one edge later
// RULE15 - with enable clear, pin enables do nothing and no destination gets voltage
package ldc_pkg;
    localparam int REG_AW = 4;
    localparam int DATA_W = 8;
    localparam int LEVEL_W = 5;
    localparam int CHAN_W = 6;
    localparam logic [REG_AW-1:0] ADDR_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] ADDR_LEVEL = 4'h1;
    localparam logic [REG_AW-1:0] ADDR_STATUS = 4'h2;
    localparam int BIT_EN = 7;
    localparam int BIT_OE1 = 5;
    localparam int BIT_OE2 = 4;
    localparam int BIT_PSS_HI = 3;
    localparam int BIT_PSS_LO = 2;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h00;
    localparam logic [CHAN_W-1:0] CHAN_DAC = 6'h3d;
    typedef enum logic [1:0] {
        SRC_SUPPLY = 2'b00,
        SRC_EXT_PIN = 2'b01,
        SRC_FIXED = 2'b10,
        SRC_RSVD = 2'b11
    } ldc_src_e;
endpackage

// >>> design/ldc_regs_if.sv
// bundle of decoded control fields passed from the register file to the router
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface ldc_regs_if;
    import ldc_pkg::*;
    logic enable;
    logic oe1;
    logic oe2;
    ldc_src_e srcSel;
    logic [LEVEL_W-1:0] level;
    modport regs (output enable, oe1, oe2, srcSel, level);
    modport route (input enable, oe1, oe2, srcSel, level);
endinterface

// >>> design/ldc_regfile.sv
// control and level registers with the plain strobe port
// assumes one strobe at a time and read data taken the cycle after the strobe
`timescale 1ns/1ps
module ldc_regfile
    import ldc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] statusIn,
    output logic [DATA_W-1:0] regRdata,
    ldc_regs_if.regs ctl
);
    logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
    logic [LEVEL_W-1:0] level_r, level_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        ctrl_nxt = ctrl_r;
        level_nxt = level_r;
        rdata_nxt = rdata_r;
        // sleep does not reset anything: only rst_b clears state
        if (regWr && regAddr == ADDR_CTRL) begin // RULE9
            ctrl_nxt = '0;
            ctrl_nxt[BIT_EN] = regWdata[BIT_EN]; // RULE1
            ctrl_nxt[BIT_OE1] = regWdata[BIT_OE1]; // RULE6
            ctrl_nxt[BIT_OE2] = regWdata[BIT_OE2];
            ctrl_nxt[BIT_PSS_HI:BIT_PSS_LO] = regWdata[BIT_PSS_HI:BIT_PSS_LO]; // RULE14
        end
        if (regWr && regAddr == ADDR_LEVEL) begin
            level_nxt = regWdata[LEVEL_W-1:0]; // RULE14
        end
        if (regRd) begin
            case (regAddr)
                ADDR_CTRL: rdata_nxt = ctrl_r;
                ADDR_LEVEL: rdata_nxt = {{(DATA_W-LEVEL_W){1'b0}}, level_r}; // RULE12
                ADDR_STATUS: rdata_nxt = statusIn;
                default: rdata_nxt = '0;
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RESET; // RULE10
            level_r <= LEVEL_RESET; // RULE10
            rdata_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            level_r <= level_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign regRdata = rdata_r;
    assign ctl.enable = ctrl_r[BIT_EN];
    assign ctl.oe1 = ctrl_r[BIT_OE1];
    assign ctl.oe2 = ctrl_r[BIT_OE2];
    assign ctl.srcSel = ldc_src_e'(ctrl_r[BIT_PSS_HI:BIT_PSS_LO]);
    assign ctl.level = level_r;
endmodule

// >>> design/ldc_pin_ctl.sv
// override controls for one pin shared between digital i/o and reference output
// assumes padIn is already synchronised by the caller
`timescale 1ns/1ps
module ldc_pin_ctl (
    input wire logic refSel,
    input wire logic padIn,
    input wire logic digOut,
    input wire logic digOe,
    input wire logic pullUpReq,
    input wire logic currentDriveReq,
    output logic readVal,
    output logic pinOut,
    output logic pinOe,
    output logic pullUpEn,
    output logic currentDriveEn,
    output logic inputDetEn
);
    always_comb begin
        pinOut = refSel ? 1'b0 : digOut; // RULE7
        pinOe = refSel ? 1'b0 : digOe; // RULE7
        pullUpEn = pullUpReq & ~refSel; // RULE7
        currentDriveEn = currentDriveReq & ~refSel; // RULE7
        inputDetEn = ~refSel; // RULE7
        readVal = refSel ? 1'b0 : padIn; // RULE8
    end
endmodule

// >>> sim/ldc_props.sv
// port-level checks for the ladder reference converter control block
// assumes one clock ref_clk and synchronous active-low rst_b; bound at the foot
`timescale 1ns/1ps
module ldc_props
    import ldc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [REG_AW-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic [CHAN_W-1:0] adcChannelSelect,
    input wire logic [1:0] digOe,
    input wire logic [1:0] pullUpReq,
    input wire logic [1:0] pinReadVal,
    input wire logic [1:0] pinOe,
    input wire logic [1:0] pullUpEn,
    input wire logic [1:0] inputDetEn,
    input wire logic ladderPowerEn,
    input wire logic [LEVEL_W-1:0] ladderTap,
    input wire logic srcSupplyEn,
    input wire logic srcExtPinEn,
    input wire logic srcFixedEn,
    input wire logic cmpPosConnect,
    input wire logic adcInputConnect,
    input wire logic refOutPinA,
    input wire logic refOutPinB
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // write history: a write lands on the outputs two edges later
    logic wc1, wc2, wl1, wl2, rdq;
    logic [DATA_W-1:0] wd1, wd2;
    always_ff @(posedge ref_clk) begin
        wc1 <= rst_b && regWr && regAddr == ADDR_CTRL;
        wc2 <= rst_b && wc1;
        wl1 <= rst_b && regWr && regAddr == ADDR_LEVEL;
        wl2 <= rst_b && wl1;
        rdq <= rst_b && regRd && regAddr == ADDR_LEVEL;
        wd1 <= regWdata;
        wd2 <= wd1;
    end
    ////////////////////////////////////////
    property p_ctrl;
        wc2 |-> ladderPowerEn == wd2[BIT_EN] &&
            {refOutPinB, refOutPinA} == ({wd2[BIT_OE2], wd2[BIT_OE1]} & {2{wd2[BIT_EN]}});
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control write not applied");
    property p_src;
        wc2 |-> {srcFixedEn, srcExtPinEn, srcSupplyEn} ==
            ((wd2[BIT_EN] && wd2[3:2] != 2'b11) ? 3'h1 << wd2[3:2] : 3'h0);
    endproperty
    a_src: assert property (p_src) else $error("source select wrong");
    property p_level;
        wl2 && ladderPowerEn |-> ladderTap == wd2[LEVEL_W-1:0];
    endproperty
    a_level: assert property (p_level) else $error("tap not following level");
    property p_off;
        !ladderPowerEn |-> ladderTap == 5'h00 && !cmpPosConnect && !adcInputConnect &&
            !refOutPinA && !refOutPinB && !srcSupplyEn && !srcExtPinEn && !srcFixedEn;
    endproperty
    a_off: assert property (p_off) else $error("voltage routed while off");
    property p_cmp;
        ladderPowerEn |-> cmpPosConnect;
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator not fed");
    property p_adc;
        $past(rst_b) |->
            adcInputConnect == (ladderPowerEn && $past(adcChannelSelect) == CHAN_DAC);
    endproperty
    a_adc: assert property (p_adc) else $error("adc channel routing wrong");
    property p_pass;
        $past(rst_b) |-> pinOe == ($past(digOe) & ~{refOutPinB, refOutPinA}) &&
            pullUpEn == ($past(pullUpReq) & ~{refOutPinB, refOutPinA});
    endproperty
    a_pass: assert property (p_pass) else $error("pin override wrong");
    property p_det;
        inputDetEn == ~{refOutPinB, refOutPinA};
    endproperty
    a_det: assert property (p_det) else $error("input detector wrong");
    property p_rd0;
        refOutPinA && $past(refOutPinA) |-> !pinReadVal[0];
    endproperty
    a_rd0: assert property (p_rd0) else $error("reference pin reads one");
    property p_lvl_rd;
        rdq |-> regRdata[7:5] == 3'h0;
    endproperty
    a_lvl_rd: assert property (p_lvl_rd) else $error("level upper bits set");
    c_on: cover property (wc2 && ladderPowerEn);
    c_adc: cover property (adcInputConnect);
    c_both: cover property (refOutPinA && refOutPinB);
endmodule
bind ladder_dac_control ldc_props u_props (.*);

// >>> sim/tb_ladder_dac_control.sv
// self-checking bench for the ladder reference converter control block
// assumes design sources and the bound checker are compiled before it
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_ladder_dac_control
    import ldc_pkg::*;
;
    logic ref_clk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [REG_AW-1:0] regAddr = 4'h0;
    logic [DATA_W-1:0] regWdata = 8'h00, regRdata;
    logic [CHAN_W-1:0] adcChannelSelect = 6'h00;
    logic [1:0] padIn = 2'h0, digOut = 2'h0, digOe = 2'h0, pullUpReq = 2'h0;
    logic [1:0] currentDriveReq = 2'h0, pinReadVal, pinOut, pinOe, pullUpEn;
    logic [1:0] currentDriveEn, inputDetEn;
    logic ladderPowerEn, srcSupplyEn, srcExtPinEn, srcFixedEn;
    logic cmpPosConnect, adcInputConnect, refOutPinA, refOutPinB;
    logic [LEVEL_W-1:0] ladderTap;
    int mismatches = 0;
    int cmp_count = 0;
    ladder_dac_control u_dut (.*);
    initial forever #10 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task automatic bus(input logic w, input logic r, input logic [REG_AW-1:0] a,
            input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
    endtask
    task automatic rd(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1;
        `CHK("rdata", e, regRdata)
    endtask
    task automatic check(input logic [DATA_W-1:0] c, input logic [LEVEL_W-1:0] l);
        logic en, a, b, ad;
        logic [1:0] m;
        logic [2:0] s;
        en = c[BIT_EN];
        a = en & c[BIT_OE1];
        b = en & c[BIT_OE2];
        ad = en && adcChannelSelect == CHAN_DAC;
        m = ~{b, a};
        s = (en && c[3:2] != 2'b11) ? 3'h1 << c[3:2] : 3'h0;
        `CHK("power", en, ladderPowerEn)
        `CHK("tap", en ? l : 5'h00, ladderTap)
        `CHK("src", s, {srcFixedEn, srcExtPinEn, srcSupplyEn})
        `CHK("cmp", en, cmpPosConnect)
        `CHK("adc", ad, adcInputConnect)
        `CHK("refs", {b, a}, {refOutPinB, refOutPinA})
        `CHK("oe", digOe & m, pinOe)
        `CHK("out", digOut & m, pinOut)
        `CHK("pull", pullUpReq & m, pullUpEn)
        `CHK("drive", currentDriveReq & m, currentDriveEn)
        `CHK("det", m, inputDetEn)
        `CHK("read", padIn & m, pinReadVal)
        rd(ADDR_CTRL, c & 8'hbc);
        rd(ADDR_LEVEL, {3'h0, l});
        rd(ADDR_STATUS, {4'h0, ad, en, b, a});
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        int i;
        logic [DATA_W-1:0] c;
        logic [LEVEL_W-1:0] l;
        void'($urandom(45));
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        // look after the edge so nothing is read in the step that launches it
        #1;
        check(8'h00, 5'h00);
        $display("test reset values done");
        for (i = 0; i < 48; i++) begin
            c = 8'($urandom);
            c[3:2] = i[1:0];
            l = i < 2 ? {5{i[0]}} : 5'($urandom);
            bus(1'b1, 1'b0, ADDR_CTRL, c);
            padIn <= 2'($urandom);
            digOut <= 2'($urandom);
            digOe <= 2'($urandom);
            pullUpReq <= 2'($urandom);
            currentDriveReq <= 2'($urandom);
            adcChannelSelect <= i[2] ? CHAN_DAC : 6'($urandom);
            bus(1'b1, 1'b0, ADDR_LEVEL, {3'h7, l});
            bus(1'b0, 1'b0, ADDR_CTRL, 8'h00);
            repeat (3) @(posedge ref_clk);
            #1;
            check(c, l);
        end
        $display("test random settings done");
        // read-only and unmapped places must swallow writes
        bus(1'b1, 1'b0, ADDR_STATUS, 8'hff);
        bus(1'b1, 1'b0, 4'h7, 8'hff);
        rd(4'h7, 8'h00);
        check(c, l);
        $display("test unmapped access done");
        bus(1'b1, 1'b0, ADDR_CTRL, 8'hb0);
        bus(1'b1, 1'b0, ADDR_LEVEL, 8'h15);
        bus(1'b0, 1'b0, ADDR_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        // prove the converter is running before reset is asked to clear it
        check(8'hb0, 5'h15);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        // pad read path needs two sync stages plus the output flop after release
        repeat (3) @(posedge ref_clk);
        #1;
        check(8'h00, 5'h00);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
